// ==== src/uaef_flag_if.sv ====
// carrier between the top block and one sticky flag register
// assumes owner and user share the core clock
`timescale 1ns/1ps
interface uaef_flag_if #(parameter int W = 8);
    logic [W-1:0] set;
    logic         wr;
    logic [W-1:0] wdata;
    logic [W-1:0] flags;

    modport owner (input set, input wr, input wdata, output flags);
    modport user  (output set, output wr, output wdata, input flags);
endinterface

// ==== src/uaef_flag_reg.sv ====
// one register of sticky event flags, set by hardware, cleared by writing 0
// assumes set and wr are single-cycle strobes on the core clock
`timescale 1ns/1ps
module uaef_flag_reg
    import uaef_pkg::*;
#(
    parameter int           W   = 8,
    parameter logic [W-1:0] RST = '0
)(
    input  wire logic clock,   // core clock
    input  wire logic rst_n,   // synchronised reset, active low
    uaef_flag_if.owner fl      // set, write and flag value
);
    typedef struct packed
    {
        logic [W-1:0] flags;
    } uaef_flag_st_t;

    uaef_flag_st_t s_q;
    uaef_flag_st_t s_d;

    always_comb
    begin
        s_d = s_q;
        // a written 1 keeps the flag; only hardware raises one
        if (fl.wr)
        begin
            s_d.flags = s_q.flags & fl.wdata;   // see R13
        end
        // set applied last so a same-cycle clear loses
        s_d.flags = s_d.flags | fl.set;          // see R23
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q.flags <= RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign fl.flags = s_q.flags;

    property p_flag_hold;
        @(posedge clock) disable iff (!rst_n)
        (s_q.flags[0] && !fl.wr) |=> s_q.flags[0];
    endproperty
    a_flag_hold: assert property (p_flag_hold) // see R13
        else $error("flag dropped without a write");

endmodule

// ==== src/uaef_pkg.sv ====
// constants for the usb address and event flag block
// assumes a 32-bit apb slave port and one 125 mhz core clock
package uaef_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] CTRL_IDX  = 8'h10;
    localparam logic [7:0] EPEV_IDX  = 8'h11;
    localparam logic [7:0] FNEV_IDX  = 8'h12;
    localparam logic [7:0] CTRL_ADDR = {CTRL_IDX[5:0], 2'b00};
    localparam logic [7:0] EPEV_ADDR = {EPEV_IDX[5:0], 2'b00};
    localparam logic [7:0] FNEV_ADDR = {FNEV_IDX[5:0], 2'b00};

    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] EPEV_RST = 8'h00;
    localparam logic [6:0] FNEV_RST = 7'h00;

    // field widths and positions
    localparam int EP_W      = 8;
    localparam int FN_W      = 7;
    localparam int ADDR_W    = 7;
    localparam int CTRL_EN   = 7;
    localparam int EP_SETUP  = 7;
    localparam int EP_OUT0   = 6;
    localparam int EP_TX0    = 5;
    localparam int EP_TX1    = 4;
    localparam int EP_TX2    = 3;
    localparam int EP_SUSP   = 2;
    localparam int EP_TX3    = 1;
    localparam int EP_RX4    = 0;
    localparam int FN_BPWR   = 6;
    localparam int FN_WAKE   = 5;
    localparam int FN_BRST   = 4;
    localparam int FN_RSM    = 3;
    localparam int FN_KEY    = 2;
    localparam int FN_PB0    = 1;
    localparam int FN_TM0    = 0;

    localparam logic [6:0] ADDR_ZERO = 7'h00;

endpackage

// ==== src/uaef_top.sv ====
// usb function enable, device address and two sticky event flag registers
// assumes an apb master on the core clock; event strobes come from logic
// on the same clock, pins are asynchronous and are synchronised here
//
// Behaviour
// R1 - usb function enabled only while bit 7 set
// R2 - seven-bit address in low bits, reset zero
// R3 - stored address zero answers bus address zero
// R4 - firmware writes assigned address, device then matches
// R5 - endpoint0 setup packet sets flag bit 7
// R6 - endpoint0 out data received sets bit 6
// R7 - endpoint0 transmit done sets bit 5
// R8 - endpoint1 interrupt-in transmit sets bit 4
// R9 - endpoint2 interrupt-in transmit sets bit 3
// R10 - suspend detect sets bit 2; clear ends suspend
// R11 - endpoint3 bulk-in done sets bit 1
// R12 - endpoint4 bulk-out received sets bit 0
// R13 - flags stay set until written zero
// R14 - firmware clears by whole-register writes only
// R15 - bus power attach on sense pin sets flag
// R16 - wake timer timeout sets flag
// R17 - host bus reset sets flag
// R18 - resume while suspended sets flag
// R19 - keyboard scan line event sets flag
// R20 - port b pin zero falling edge sets flag
// R21 - timer0 overflow sets flag
// R22 - function flags bits six..zero, bit seven unused
// R23 - simultaneous set and clear leaves flag set
`timescale 1ns/1ps
module uaef_top
    import uaef_pkg::*;
(
    input  wire logic        clock,                 // core clock, 125 mhz
    input  wire logic        arst_n,                // async reset, low
    input  wire logic        psel,                  // apb select
    input  wire logic        penable,               // apb enable
    input  wire logic        pwrite,                // apb write
    input  wire logic [7:0]  paddr,                 // apb byte address
    input  wire logic [31:0] pwdata,                // apb write data
    input  wire logic [3:0]  pstrb,                 // apb byte strobes
    output logic      [31:0] prdata,                // apb read data
    output logic             pready,                // apb ready
    output logic             pslverr,               // apb error
    input  wire logic        ep0_setup_evt,         // ep0 setup received
    input  wire logic        ep0_out_evt,           // ep0 out data in fifo
    input  wire logic        ep0_tx_evt,            // ep0 transmit done
    input  wire logic        ep1_tx_evt,            // ep1 interrupt-in sent
    input  wire logic        ep2_tx_evt,            // ep2 interrupt-in sent
    input  wire logic        suspend_evt,           // bus suspend seen
    input  wire logic        ep3_tx_evt,            // ep3 bulk-in done
    input  wire logic        ep4_rx_evt,            // ep4 bulk-out received
    input  wire logic        bus_reset_evt,         // host bus reset
    input  wire logic        resume_evt,            // resume signalling
    input  wire logic        wake_timer_evt,        // wake timer timeout
    input  wire logic        timer0_ovf_evt,        // timer0 overflow
    input  wire logic        bus_power_sense_pin,   // vbus sense pin
    input  wire logic [7:0]  key_scan_inputs,       // keyboard scan lines
    input  wire logic        port_b_pin_zero,       // port b pin 0
    input  wire logic        token_valid,           // token address valid
    input  wire logic [6:0]  token_addr,            // token device address
    output logic             usb_function_enable,   // usb function on
    output logic      [6:0]  device_address_field,  // stored address
    output logic             addr_match,            // token is for us
    output logic             suspended,             // device in suspend
    output logic      [7:0]  endpoint_event_flags,  // endpoint flags
    output logic      [6:0]  function_event_flags   // function flags
);

    ////////////////////////////////////////////////////////////////////////
    // reset release

    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_sync_q <= 2'b00;
        end
        else
        begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed
    {
        logic        bp_s1;
        logic        bp_s2;
        logic        bp_prev;
        logic [7:0]  kb_s1;
        logic [7:0]  kb_s2;
        logic [7:0]  kb_prev;
        logic        pb_s1;
        logic        pb_s2;
        logic        pb_prev;
        logic [7:0]  ctrl;
        logic [31:0] rdata;
        logic        ready;
        logic        err;
        logic        match;
    } uaef_state_t;

    uaef_state_t s_q;
    uaef_state_t s_d;

    uaef_flag_if #(.W(EP_W)) ep_if ();
    uaef_flag_if #(.W(FN_W)) fn_if ();

    logic setup_ph;
    logic access_done;
    logic hit_ctrl;
    logic hit_epev;
    logic hit_fnev;
    logic wr_low;
    logic bp_rise;
    logic pb_fall;
    logic kb_fall;

    always_comb
    begin
        setup_ph    = psel && !penable;
        access_done = psel && penable && s_q.ready;
        hit_ctrl    = (paddr == CTRL_ADDR);
        hit_epev    = (paddr == EPEV_ADDR);
        hit_fnev    = (paddr == FNEV_ADDR);
        // only the low byte lane holds data
        wr_low      = access_done && pwrite && pstrb[0] && !s_q.err;
        bp_rise     = s_q.bp_s2 && !s_q.bp_prev;
        pb_fall     = !s_q.pb_s2 && s_q.pb_prev;
        // a key press pulls a scan line low
        kb_fall     = |(~s_q.kb_s2 & s_q.kb_prev);
    end

    ////////////////////////////////////////////////////////////////////////
    // flag registers

    always_comb
    begin
        ep_if.set           = '0;
        ep_if.set[EP_SETUP] = ep0_setup_evt;                   // see R5
        ep_if.set[EP_OUT0]  = ep0_out_evt;                     // see R6
        ep_if.set[EP_TX0]   = ep0_tx_evt;                      // see R7
        ep_if.set[EP_TX1]   = ep1_tx_evt;                      // see R8
        ep_if.set[EP_TX2]   = ep2_tx_evt;                      // see R9
        ep_if.set[EP_SUSP]  = suspend_evt;                     // see R10
        ep_if.set[EP_TX3]   = ep3_tx_evt;                      // see R11
        ep_if.set[EP_RX4]   = ep4_rx_evt;                      // see R12
        ep_if.wr            = wr_low && hit_epev;              // see R13
        ep_if.wdata         = pwdata[EP_W-1:0];

        // bits 6..0 of the function register; bit 7 has no storage
        fn_if.set           = '0;                              // see R22
        fn_if.set[FN_BPWR]  = bp_rise;                         // see R15
        fn_if.set[FN_WAKE]  = wake_timer_evt;                  // see R16
        fn_if.set[FN_BRST]  = bus_reset_evt;                   // see R17
        // resume only counts while the suspend flag stands
        fn_if.set[FN_RSM]   = resume_evt && ep_if.flags[EP_SUSP]; // see R18
        fn_if.set[FN_KEY]   = kb_fall;                         // see R19
        fn_if.set[FN_PB0]   = pb_fall;                         // see R20
        fn_if.set[FN_TM0]   = timer0_ovf_evt;                  // see R21
        fn_if.wr            = wr_low && hit_fnev;
        fn_if.wdata         = pwdata[FN_W-1:0];
    end

    uaef_flag_reg #(.W(EP_W), .RST(EPEV_RST)) u_ep_flags
    (
        .clock (clock),
        .rst_n (rst_n),
        .fl    (ep_if.owner)
    );

    uaef_flag_reg #(.W(FN_W), .RST(FNEV_RST)) u_fn_flags
    (
        .clock (clock),
        .rst_n (rst_n),
        .fl    (fn_if.owner)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        s_d         = s_q;
        s_d.bp_s1   = bus_power_sense_pin;
        s_d.bp_s2   = s_q.bp_s1;
        s_d.bp_prev = s_q.bp_s2;
        s_d.kb_s1   = key_scan_inputs;
        s_d.kb_s2   = s_q.kb_s1;
        s_d.kb_prev = s_q.kb_s2;
        s_d.pb_s1   = port_b_pin_zero;
        s_d.pb_s2   = s_q.pb_s1;
        s_d.pb_prev = s_q.pb_s2;

        // answer is prepared in the setup cycle, so access lasts one cycle
        s_d.ready   = setup_ph;
        s_d.err     = setup_ph && !(hit_ctrl || hit_epev || hit_fnev);
        s_d.rdata   = 32'h0000_0000;
        if (setup_ph && !pwrite)
        begin
            if (hit_ctrl)
            begin
                s_d.rdata[7:0] = s_q.ctrl;                     // see R4
            end
            else if (hit_epev)
            begin
                s_d.rdata[EP_W-1:0] = ep_if.flags;
            end
            else if (hit_fnev)
            begin
                s_d.rdata[FN_W-1:0] = fn_if.flags;
            end
        end

        if (wr_low && hit_ctrl)
        begin
            s_d.ctrl = pwdata[7:0];                            // see R1
        end

        // matching stops while the function is disabled
        s_d.match = token_valid && s_q.ctrl[CTRL_EN]           // see R1
                    && (token_addr == s_q.ctrl[ADDR_W-1:0]);   // see R3
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q         <= '0;
            s_q.ctrl    <= CTRL_RST;                           // see R2
        end
        else
        begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign prdata               = s_q.rdata;
    assign pready               = s_q.ready;
    assign pslverr              = s_q.err;
    assign usb_function_enable  = s_q.ctrl[CTRL_EN];
    assign device_address_field = s_q.ctrl[ADDR_W-1:0];
    assign addr_match           = s_q.match;                   // see R4
    assign suspended            = ep_if.flags[EP_SUSP];        // see R10
    assign endpoint_event_flags = ep_if.flags;
    assign function_event_flags = fn_if.flags;

    ////////////////////////////////////////////////////////////////////////
    // checks

    property p_enable_write;
        @(posedge clock) disable iff (!rst_n)
        (wr_low && hit_ctrl) |=> (usb_function_enable == $past(pwdata[7]));
    endproperty
    a_enable_write: assert property (p_enable_write) // see R1
        else $error("enable bit not taken from write");

    property p_addr_write;
        @(posedge clock) disable iff (!rst_n)
        (wr_low && hit_ctrl)
        |=> (device_address_field == $past(pwdata[6:0]));
    endproperty
    a_addr_write: assert property (p_addr_write) // see R2
        else $error("address field not taken from write");

    property p_match_zero;
        @(posedge clock) disable iff (!rst_n)
        (token_valid && usb_function_enable
         && device_address_field == ADDR_ZERO && token_addr == ADDR_ZERO)
        |=> addr_match;
    endproperty
    a_match_zero: assert property (p_match_zero) // see R3
        else $error("address zero not answered");

    property p_no_match;
        @(posedge clock) disable iff (!rst_n)
        (!token_valid || !usb_function_enable
         || token_addr != device_address_field) |=> !addr_match;
    endproperty
    a_no_match: assert property (p_no_match) // see R4
        else $error("foreign or disabled token matched");

    property p_setup_flag;
        @(posedge clock) disable iff (!rst_n)
        ep0_setup_evt |=> endpoint_event_flags[EP_SETUP];
    endproperty
    a_setup_flag: assert property (p_setup_flag) // see R5
        else $error("setup flag not set");

    property p_suspend;
        @(posedge clock) disable iff (!rst_n)
        suspend_evt |=> suspended;
    endproperty
    a_suspend: assert property (p_suspend) // see R10
        else $error("suspend not entered");

    property p_bus_power;
        @(posedge clock) disable iff (!rst_n)
        bp_rise |=> function_event_flags[FN_BPWR];
    endproperty
    a_bus_power: assert property (p_bus_power) // see R15
        else $error("bus power flag not set");

    property p_pb_fall;
        @(posedge clock) disable iff (!rst_n)
        $fell(s_q.pb_s2) |=> function_event_flags[FN_PB0];
    endproperty
    a_pb_fall: assert property (p_pb_fall) // see R20
        else $error("pin edge flag not set");

    property p_resume_gate;
        @(posedge clock) disable iff (!rst_n)
        (!function_event_flags[FN_RSM] && !suspended)
        |=> !function_event_flags[FN_RSM];
    endproperty
    a_resume_gate: assert property (p_resume_gate) // see R18
        else $error("resume flag set outside suspend");

    property p_set_wins;
        @(posedge clock) disable iff (!rst_n)
        (ep4_rx_evt && ep_if.wr && !pwdata[EP_RX4])
        |=> endpoint_event_flags[EP_RX4];
    endproperty
    a_set_wins: assert property (p_set_wins) // see R23
        else $error("event lost to a same-cycle clear");

    property p_ready_once;
        @(posedge clock) disable iff (!rst_n)
        pready |=> !pready;
    endproperty
    a_ready_once: assert property (p_ready_once)
        else $error("ready held longer than one cycle");

    c_addr_set: cover property (@(posedge clock) disable iff (!rst_n)
        wr_low && hit_ctrl && pwdata[7] && pwdata[6:0] != ADDR_ZERO);
    c_match: cover property (@(posedge clock) disable iff (!rst_n)
        addr_match && device_address_field != ADDR_ZERO);
    c_resume: cover property (@(posedge clock) disable iff (!rst_n)
        fn_if.set[FN_RSM]);
    c_clash: cover property (@(posedge clock) disable iff (!rst_n)
        ep4_rx_evt && ep_if.wr && !pwdata[EP_RX4]);

endmodule

// ==== testbench/testbench.sv ====
// self-checking bench for the usb address and event flag block
// assumes the apb slave answers with pready; flags are read on clock edges
`timescale 1ns/1ps
module testbench;
    import uaef_pkg::*;

    logic        clock = 1'b0;
    logic        arst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hF;
    logic [3:0]  cur_strb = 4'hF;
    logic [31:0] prdata, rd_data;
    logic        pready, pslverr, rd_err;
    logic [7:0]  ep_pul = 8'h00;
    logic [7:0]  race_ep = 8'h00;
    logic [6:0]  fn_pul = 7'h00;
    logic        bus_power_sense_pin = 1'b0;
    logic [7:0]  key_scan_inputs = 8'h00;
    logic        port_b_pin_zero = 1'b0;
    logic        tok_go = 1'b0;
    logic [6:0]  tok_dst = 7'h00;
    logic        token_valid, bus_reset_evt, suspend_evt, resume_evt;
    logic [6:0]  token_addr, device_address_field, function_event_flags;
    logic        usb_function_enable, addr_match, suspended;
    logic [7:0]  endpoint_event_flags, v, w, ev, exp_ep, ctrl_exp;
    logic        ep0_setup_evt, ep0_out_evt, ep0_tx_evt, ep1_tx_evt;
    logic        ep2_tx_evt, ep3_tx_evt, ep4_rx_evt;
    logic        wake_timer_evt, timer0_ovf_evt;
    int          fails = 0;
    int          samples_checked = 0;
    int          seed = 91;
    int          i;

    assign {ep0_setup_evt, ep0_out_evt, ep0_tx_evt} = ep_pul[7:5];
    assign {ep1_tx_evt, ep2_tx_evt} = ep_pul[4:3];
    assign {ep3_tx_evt, ep4_rx_evt} = ep_pul[1:0];
    assign wake_timer_evt = fn_pul[5];
    assign timer0_ovf_evt = fn_pul[0];

    always #4 clock = ~clock;

    uaef_host_model host (.clock, .tok_go, .tok_dst,
        .sig_go({fn_pul[3], ep_pul[2], fn_pul[4]}), .token_valid,
        .token_addr, .bus_reset_evt, .suspend_evt, .resume_evt);

    uaef_top DUT (.clock, .arst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .ep0_setup_evt,
        .ep0_out_evt, .ep0_tx_evt, .ep1_tx_evt, .ep2_tx_evt, .suspend_evt,
        .ep3_tx_evt, .ep4_rx_evt, .bus_reset_evt, .resume_evt,
        .wake_timer_evt, .timer0_ovf_evt, .bus_power_sense_pin,
        .key_scan_inputs, .port_b_pin_zero, .token_valid, .token_addr,
        .usb_function_enable, .device_address_field, .addr_match,
        .suspended, .endpoint_event_flags, .function_event_flags);

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    function automatic logic [7:0] cleared(input logic [7:0] old,
        input logic [7:0] wd, input logic [7:0] set);
        return (old & wd) | set;
    endfunction

    // entered just after a rising edge; one idle cycle follows each transfer
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [7:0] d);
        int          n;
        logic [31:0] r;
        r = $random(seed);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {r[31:8], d};
        pstrb <= cur_strb;
        @(posedge clock);
        penable <= 1'b1;
        ep_pul <= race_ep;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        chk("pready", 1, pready);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        ep_pul <= 8'h00;
        @(posedge clock);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk("read data", {24'h0, e}, rd_data);
        chk("read error", 0, rd_err);
    endtask

    task automatic pulse(input logic [7:0] ep, input logic [6:0] fn);
        ep_pul <= ep;
        fn_pul <= fn;
        @(posedge clock);
        ep_pul <= 8'h00;
        fn_pul <= 7'h00;
        cyc(3);
    endtask

    task automatic tok(input logic [6:0] a, input logic e);
        tok_go <= 1'b1;
        tok_dst <= a;
        @(posedge clock);
        tok_go <= 1'b0;
        cyc(2);
        chk("addr match", e, addr_match);
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        #160000;
        fails++;
        conclude();
    end

    initial
    begin
        cyc(2);
        arst_n <= 1'b1;
        cyc(4);
        chk("outputs", 0, {usb_function_enable, endpoint_event_flags});
        rdchk(CTRL_ADDR, CTRL_RST);
        rdchk(EPEV_ADDR, EPEV_RST);
        rdchk(FNEV_ADDR, {1'b0, FNEV_RST});
        $display("test reset values done");

        for (i = 0; i < 14; i++)
        begin
            v = (i < 4) ? 8'h81 >> (7 * (i % 2)) ^ {8{i[1]}} : $random(seed);
            apb(1'b1, CTRL_ADDR, v);
            ctrl_exp = v;
            chk("enable", v[7], usb_function_enable);
            chk("address", v[6:0], device_address_field);
            rdchk(CTRL_ADDR, v);
            tok(v[6:0], v[7]);
            tok(v[6:0] ^ 7'h40, 1'b0);
        end
        $display("test control register done");

        for (i = 0; i < 8; i++)
        begin
            v = 8'h01 << i;
            pulse(v, 7'h00);
            chk("ep flags", v, endpoint_event_flags);
            chk("suspended", v[2], suspended);
            apb(1'b1, EPEV_ADDR, 8'hFF);
            rdchk(EPEV_ADDR, v);
            apb(1'b1, EPEV_ADDR, 8'h00);
            rdchk(EPEV_ADDR, 8'h00);
            chk("suspended", 0, suspended);
        end
        $display("test endpoint flags done");

        pulse(8'h00, 7'h08);
        chk("fn flags", 0, function_event_flags);
        pulse(8'h00, 7'h31);
        chk("fn flags", 7'h31, function_event_flags);
        pulse(8'h04, 7'h00);
        pulse(8'h00, 7'h08);
        chk("fn flags", 7'h39, function_event_flags);
        bus_power_sense_pin <= 1'b1;
        cyc(6);
        chk("fn flags", 7'h79, function_event_flags);
        key_scan_inputs <= 8'hFF;
        port_b_pin_zero <= 1'b1;
        cyc(6);
        chk("fn flags", 7'h79, function_event_flags);
        key_scan_inputs <= 8'hF7;
        cyc(6);
        chk("fn flags", 7'h7D, function_event_flags);
        port_b_pin_zero <= 1'b0;
        cyc(6);
        chk("fn flags", 7'h7F, function_event_flags);
        rdchk(FNEV_ADDR, 8'h7F);
        apb(1'b1, FNEV_ADDR, 8'h00);
        rdchk(FNEV_ADDR, 8'h00);
        apb(1'b1, EPEV_ADDR, 8'h00);
        $display("test function flags done");

        cur_strb = 4'hE;
        apb(1'b1, CTRL_ADDR, ~ctrl_exp);
        cur_strb = 4'hF;
        apb(1'b1, 8'h4C, 8'h5A);
        chk("unmapped error", 1, rd_err);
        apb(1'b0, 8'h4C, 8'h00);
        chk("unmapped error", 1, rd_err);
        chk("unmapped data", 0, rd_data);
        rdchk(CTRL_ADDR, ctrl_exp);
        $display("test refused accesses done");

        pulse(8'h81, 7'h00);
        race_ep = 8'h01;
        apb(1'b1, EPEV_ADDR, 8'h00);
        race_ep = 8'h00;
        rdchk(EPEV_ADDR, 8'h01);
        apb(1'b1, EPEV_ADDR, 8'h00);
        exp_ep = 8'h00;
        for (i = 0; i < 40; i++)
        begin
            ev = $random(seed);
            w = $random(seed);
            race_ep = (i % 3 == 0) ? $random(seed) : 8'h00;
            pulse(ev, 7'h00);
            apb(1'b1, EPEV_ADDR, w);
            exp_ep = cleared(exp_ep | ev, w, race_ep);
            race_ep = 8'h00;
            cyc(2);
            rdchk(EPEV_ADDR, exp_ep);
        end
        $display("test random flag traffic done");
        conclude();
    end
endmodule

// ==== testbench/uaef_host_model.sv ====
// usb host side model: bus tokens and bus signalling strobes
// assumes requests come from the bench on the core clock
`timescale 1ns/1ps
module uaef_host_model (
    input  wire logic       clock,         // core clock
    input  wire logic       tok_go,        // send one token
    input  wire logic [6:0] tok_dst,       // token target address
    input  wire logic [2:0] sig_go,        // resume, suspend, reset
    output logic            token_valid,   // token on the bus
    output logic      [6:0] token_addr,    // token address
    output logic            bus_reset_evt, // host reset signalling
    output logic            suspend_evt,   // bus idle long enough
    output logic            resume_evt     // resume signalling
);
    initial token_valid = 1'b0;
    initial token_addr = 7'h00;
    initial {bus_reset_evt, suspend_evt, resume_evt} = 3'h0;

    always @(posedge clock)
    begin
        token_valid <= tok_go;
        // between tokens the address lines alternate each cycle between the last address and its inverse
        token_addr <= tok_go ? tok_dst : ~token_addr;
        bus_reset_evt <= sig_go[0];
        suspend_evt <= sig_go[1];
        resume_evt <= sig_go[2];
    end
endmodule
